// *** src/segx_top.sv ***
`timescale 1ns/1ps
`include "segx_cfg.svh"
// Summary of operation
// [RULE1] Code segment resets zero, drives A21-16.
// [RULE2] Segment bits 7:6 reserved, read zero.
// [RULE3] Interrupt segment addresses vectors and routines.
// [RULE4] DMA with choice clear uses interrupt segment.
// [RULE5] DMA with choice set uses DMA segment.
// [RULE6] Save disabled: interrupt segment replaces code segment.
// [RULE7] Save enabled: push code segment, load interrupt segment.
// [RULE8] Save enabled: interrupt return restores code segment.
// [RULE9] Software avoids direct code segment writes.
// [RULE10] Code segment writable only while unused; the code accepts code segment writes at any time.
// [RULE11] Compatibility routine segment jumps update register only.
// [RULE12] Data mapping unchanged during interrupt service.
// [RULE13] Relocate bit swaps page and port registers.
// [RULE14] Vectors fetched from bytes 0-5, high first.
// [RULE15] Top two bits select page, joined to 14.
// [RULE16] Program address is segment over 16 bits.
// [RULE17] Reserved segment bit writes are ignored.
module segx_top #(
  parameter int DEPTH_W = 4 // Width of the compatibility nesting counter.
) (
  input  logic                    clk_sys,        // System clock.
  input  logic                    reset_n,        // Asynchronous reset, active low.
  input  logic [5:0]              reg_page,       // Current register page.
  input  logic [7:0]              reg_addr,       // Register number.
  input  logic                    reg_wr,         // Register write strobe.
  input  logic                    reg_rd,         // Register read strobe.
  input  logic [7:0]              reg_wdata,      // Write data.
  output logic [7:0]              reg_rdata,      // Read data, one cycle later.
  output logic                    reg_hit,        // Read hit one of our registers.
  output logic                    port_remap,     // Port data registers moved to page.
  input  logic                    acc_valid,      // Memory access request.
  input  segx_pkg::segx_kind_type acc_kind,       // Code, data or DMA.
  input  logic [15:0]             acc_vaddr,      // Virtual address.
  input  logic                    dma_seg_choice, // DMA segment choice bit.
  output logic                    phys_valid,     // Physical address valid.
  output logic [21:0]             phys_addr,      // Physical address.
  input  logic                    int_enter,      // Interrupt entry pulse.
  input  logic                    iret,           // Interrupt return pulse.
  input  logic [5:0]              iret_seg,       // Code segment popped by return.
  input  logic                    seg_load,       // Segment jump, call or return.
  input  logic [5:0]              seg_load_val,   // New code segment.
  output logic                    push_seg_valid, // Push code segment this cycle.
  output logic [5:0]              push_seg,       // Code segment to push.
  output logic                    in_service,     // Compatibility service routine active.
  input  logic                    vec_req,        // Vector fetch request.
  input  segx_pkg::segx_vec_type  vec_sel,        // Which vector.
  output logic                    vec_mem_valid,  // Vector byte read request.
  output logic [21:0]             vec_mem_addr,   // Vector byte address.
  input  logic [7:0]              mem_rdata,      // Program byte.
  input  logic                    mem_rvalid,     // Program byte valid.
  output logic                    vec_done,       // Vector assembled pulse.
  output logic [15:0]             vec_target,     // Routine address.
  output logic                    vec_busy        // Vector fetch in progress.
);
  logic [5:0]           code_segment, next_cseg;
  logic [5:0]           interrupt_segment, next_iseg;
  logic [5:0]           dma_segment, next_dseg;
  logic [3:0][7:0]      data_page_select, next_page;
  logic                 save_code_segment_enable, next_save;
  logic                 page_register_relocate, next_reloc;
  logic [DEPTH_W-1:0]   depth, next_depth;
  logic                 next_in_service;
  logic [7:0]           next_rdata;
  logic                 next_hit;
  logic                 next_push_valid;
  logic [5:0]           next_push_seg;
  segx_pkg::segx_rsel_type wsel, rsel;

  // Decode one register access; page registers move to group E when relocated.
  function automatic segx_pkg::segx_rsel_type reg_decode(input logic [5:0] pg, input logic [7:0] ad,
                                                         input logic rl);
    reg_decode = segx_pkg::rsel_none;
    if (rl && (ad & `SEGX_BLK_MASK) == `SEGX_OFF_PAGE0_ALT) begin
      reg_decode = segx_pkg::rsel_page; // [RULE13]
    end else if (pg == `SEGX_PAGE_MMU) begin
      if (!rl && (ad & `SEGX_BLK_MASK) == `SEGX_OFF_PAGE0) begin
        reg_decode = segx_pkg::rsel_page;
      end else if (ad == `SEGX_OFF_CSEG) begin
        reg_decode = segx_pkg::rsel_cseg;
      end else if (ad == `SEGX_OFF_ISEG) begin
        reg_decode = segx_pkg::rsel_iseg;
      end else if (ad == `SEGX_OFF_DSEG) begin
        reg_decode = segx_pkg::rsel_dma;
      end else if (ad == `SEGX_OFF_MODE) begin
        reg_decode = segx_pkg::rsel_mode;
      end
    end
  endfunction : reg_decode

  assign wsel = reg_decode(reg_page, reg_addr, page_register_relocate);
  assign rsel = reg_decode(reg_page, reg_addr, page_register_relocate);

  // Register writes first, then core events, which take priority over a same-cycle write.
  always_comb begin
    next_cseg       = code_segment;
    next_iseg       = interrupt_segment;
    next_dseg       = dma_segment;
    next_page       = data_page_select;
    next_save       = save_code_segment_enable;
    next_reloc      = page_register_relocate;
    next_depth      = depth;
    next_push_valid = 1'b0;
    next_push_seg   = push_seg;
    if (reg_wr) begin
      unique case (wsel)
        segx_pkg::rsel_cseg: next_cseg = reg_wdata[5:0]; // [RULE17] [RULE10]
        segx_pkg::rsel_iseg: next_iseg = reg_wdata[5:0]; // [RULE17]
        segx_pkg::rsel_dma:  next_dseg = reg_wdata[5:0]; // [RULE17]
        segx_pkg::rsel_page: next_page[reg_addr[1:0]] = reg_wdata;
        segx_pkg::rsel_mode: begin
          next_save  = reg_wdata[`SEGX_BIT_SAVE_CS];
          next_reloc = reg_wdata[`SEGX_BIT_RELOC]; // [RULE13]
        end
        segx_pkg::rsel_none: next_cseg = code_segment;
      endcase
    end
    // Jumps inside a compatibility routine change the register, not the fetch segment.
    if (seg_load) begin
      next_cseg = seg_load_val; // [RULE11]
    end
    if (int_enter) begin
      if (save_code_segment_enable) begin
        next_push_valid = 1'b1; // [RULE7]
        next_push_seg   = code_segment;
        next_cseg       = interrupt_segment;
      end else begin
        next_depth = depth + DEPTH_W'(1); // [RULE6]
      end
    end else if (iret) begin
      if (save_code_segment_enable) begin
        next_cseg = iret_seg; // [RULE8]
      end else if (depth != '0) begin
        next_depth = depth - DEPTH_W'(1);
      end
    end
    next_in_service = (next_depth != '0);
  end

  // Read data; reserved bits come back as zero because only six bits are stored.
  always_comb begin
    next_rdata = `SEGX_RST_BYTE;
    next_hit   = reg_rd && (rsel != segx_pkg::rsel_none);
    if (reg_rd) begin
      unique case (rsel)
        segx_pkg::rsel_cseg: next_rdata = {2'b00, code_segment}; // [RULE2]
        segx_pkg::rsel_iseg: next_rdata = {2'b00, interrupt_segment}; // [RULE2]
        segx_pkg::rsel_dma:  next_rdata = {2'b00, dma_segment}; // [RULE2]
        segx_pkg::rsel_page: next_rdata = data_page_select[reg_addr[1:0]];
        segx_pkg::rsel_mode: begin
          next_rdata[`SEGX_BIT_SAVE_CS] = save_code_segment_enable;
          next_rdata[`SEGX_BIT_RELOC]   = page_register_relocate;
        end
        segx_pkg::rsel_none: next_rdata = `SEGX_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      code_segment             <= `SEGX_RST_SEG; // [RULE1]
      interrupt_segment        <= `SEGX_RST_SEG;
      dma_segment              <= `SEGX_RST_SEG;
      data_page_select         <= {4{`SEGX_RST_PAGE}};
      save_code_segment_enable <= 1'b0;
      page_register_relocate   <= 1'b0;
      depth                    <= '0;
      in_service               <= 1'b0;
      reg_rdata                <= `SEGX_RST_BYTE;
      reg_hit                  <= 1'b0;
      port_remap               <= 1'b0;
      push_seg_valid           <= 1'b0;
      push_seg                 <= `SEGX_RST_SEG;
    end else begin
      code_segment             <= next_cseg;
      interrupt_segment        <= next_iseg;
      dma_segment              <= next_dseg;
      data_page_select         <= next_page;
      save_code_segment_enable <= next_save;
      page_register_relocate   <= next_reloc;
      depth                    <= next_depth;
      in_service               <= next_in_service;
      reg_rdata                <= next_rdata;
      reg_hit                  <= next_hit;
      port_remap               <= next_reloc;
      push_seg_valid           <= next_push_valid;
      push_seg                 <= next_push_seg;
    end
  end

  // Address former; fetches use the interrupt segment only in a compatibility routine.
  segx_map_if map ();
  assign map.acc_valid   = acc_valid;
  assign map.acc_kind    = acc_kind;
  assign map.acc_vaddr   = acc_vaddr;
  assign map.dma_choice  = dma_seg_choice;
  assign map.use_int_seg = in_service; // [RULE6]
  assign map.code_seg    = code_segment;
  assign map.int_seg     = interrupt_segment;
  assign map.dma_seg     = dma_segment;
  assign map.page        = data_page_select; // [RULE12]
  assign phys_addr       = map.phys_addr;
  assign phys_valid      = map.phys_valid;

  segx_addr_former u_former (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .m       (map)
  );

  // Vector fetch: two byte reads, high then low. Reset uses the code segment, traps the interrupt segment.
  segx_pkg::segx_vstate_type vstate, next_vstate;
  logic [21:0] next_vec_addr;
  logic        next_vec_valid, next_vec_done;
  logic [15:0] next_vec_target;

  always_comb begin
    next_vstate     = vstate;
    next_vec_addr   = vec_mem_addr;
    next_vec_valid  = vec_mem_valid;
    next_vec_done   = 1'b0;
    next_vec_target = vec_target;
    unique case (vstate)
      segx_pkg::st_idle: begin
        if (vec_req) begin
          next_vstate    = segx_pkg::st_high;
          next_vec_valid = 1'b1;
          unique case (vec_sel)
            segx_pkg::vec_reset:   next_vec_addr = {code_segment, `SEGX_VEC_RESET}; // [RULE14]
            segx_pkg::vec_divzero: next_vec_addr = {interrupt_segment, `SEGX_VEC_DIVZERO}; // [RULE3]
            segx_pkg::vec_top:     next_vec_addr = {interrupt_segment, `SEGX_VEC_TOP};
            default:               next_vec_addr = {code_segment, `SEGX_VEC_RESET};
          endcase
        end
      end
      segx_pkg::st_high: begin
        if (mem_rvalid) begin
          next_vstate           = segx_pkg::st_low;
          next_vec_target[15:8] = mem_rdata; // [RULE14]
          next_vec_addr         = vec_mem_addr + 22'h000001;
        end
      end
      segx_pkg::st_low: begin
        if (mem_rvalid) begin
          next_vstate          = segx_pkg::st_idle;
          next_vec_target[7:0] = mem_rdata;
          next_vec_valid       = 1'b0;
          next_vec_done        = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      vstate        <= segx_pkg::st_idle;
      vec_mem_addr  <= 22'h000000;
      vec_mem_valid <= 1'b0;
      vec_done      <= 1'b0;
      vec_target    <= 16'h0000;
      vec_busy      <= 1'b0;
    end else begin
      vstate        <= next_vstate;
      vec_mem_addr  <= next_vec_addr;
      vec_mem_valid <= next_vec_valid;
      vec_done      <= next_vec_done;
      vec_target    <= next_vec_target;
      vec_busy      <= (next_vstate != segx_pkg::st_idle);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_reserved_zero;
    reg_rd && (rsel == segx_pkg::rsel_cseg || rsel == segx_pkg::rsel_iseg) |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits not zero."); // [RULE2]

  property p_cseg_write_masked;
    reg_wr && wsel == segx_pkg::rsel_cseg && !seg_load && !int_enter && !iret |=> code_segment == $past(reg_wdata[5:0]);
  endproperty
  a_cseg_write_masked: assert property (p_cseg_write_masked) else $error("Code segment write lost."); // [RULE17]

  property p_code_fetch;
    acc_valid && acc_kind == segx_pkg::kind_code |=>
      phys_valid && phys_addr == {($past(in_service) ? $past(interrupt_segment) : $past(code_segment)), $past(acc_vaddr)};
  endproperty
  a_code_fetch: assert property (p_code_fetch) else $error("Code fetch address wrong."); // [RULE1] [RULE3] [RULE16]

  property p_save_entry;
    int_enter && save_code_segment_enable |=>
      push_seg_valid && push_seg == $past(code_segment) && code_segment == $past(interrupt_segment) && !in_service;
  endproperty
  a_save_entry: assert property (p_save_entry) else $error("Save-mode entry wrong."); // [RULE7]

  property p_compat_entry;
    int_enter && !save_code_segment_enable |=> in_service && !push_seg_valid;
  endproperty
  a_compat_entry: assert property (p_compat_entry) else $error("Compatibility entry wrong."); // [RULE6]

  property p_save_return;
    iret && !int_enter && save_code_segment_enable |=> code_segment == $past(iret_seg);
  endproperty
  a_save_return: assert property (p_save_return) else $error("Return did not restore segment."); // [RULE8]

  property p_compat_jump;
    seg_load && in_service && !int_enter && !iret |=> code_segment == $past(seg_load_val) && in_service;
  endproperty
  a_compat_jump: assert property (p_compat_jump) else $error("Jump in routine mishandled."); // [RULE11]

  property p_relocate;
    reg_rd && page_register_relocate && (reg_addr & `SEGX_BLK_MASK) == `SEGX_OFF_PAGE0_ALT |=>
      reg_hit && reg_rdata == $past(data_page_select[reg_addr[1:0]]);
  endproperty
  a_relocate: assert property (p_relocate) else $error("Relocated page read wrong."); // [RULE13]

  sequence s_vec_start;
    vstate == segx_pkg::st_idle && vec_req && vec_sel == segx_pkg::vec_top;
  endsequence
  sequence s_vec_high;
    vec_mem_valid && vec_mem_addr[15:0] == `SEGX_VEC_TOP;
  endsequence
  property p_vector;
    s_vec_start |=> s_vec_high;
  endproperty
  a_vector: assert property (p_vector) else $error("Vector address wrong."); // [RULE14]
endmodule : segx_top

// *** src/segx_cfg.svh ***
`ifndef SEGX_CFG_SVH
`define SEGX_CFG_SVH
// Register page and offsets inside the paged register group.
`define SEGX_PAGE_MMU      6'h15
`define SEGX_OFF_PAGE0     8'hf0
`define SEGX_OFF_PAGE0_ALT 8'he0
`define SEGX_OFF_CSEG      8'hf4
`define SEGX_OFF_MODE      8'hf6
`define SEGX_OFF_ISEG      8'hf8
`define SEGX_OFF_DSEG      8'hf9
`define SEGX_BLK_MASK      8'hfc
// Field positions in the extended mode register.
`define SEGX_BIT_RELOC     5
`define SEGX_BIT_SAVE_CS   6
// Reset values.
`define SEGX_RST_SEG       6'h00
`define SEGX_RST_PAGE      8'h00
`define SEGX_RST_BYTE      8'h00
// Program-space vector byte pairs, high byte first.
`define SEGX_VEC_RESET     16'h0000
`define SEGX_VEC_DIVZERO   16'h0002
`define SEGX_VEC_TOP       16'h0004
`endif

// *** src/segx_pkg.sv ***
package segx_pkg;
  typedef enum logic [1:0] {kind_code, kind_data, kind_dma} segx_kind_type;
  typedef enum logic [1:0] {vec_reset, vec_divzero, vec_top} segx_vec_type;
  typedef enum logic [1:0] {st_idle, st_high, st_low} segx_vstate_type;
  typedef enum logic [2:0] {rsel_none, rsel_cseg, rsel_iseg, rsel_dma, rsel_mode, rsel_page} segx_rsel_type;
endpackage : segx_pkg

// *** src/segx_map_if.sv ***
`timescale 1ns/1ps
interface segx_map_if;
  logic                     acc_valid;   // Access request this cycle.
  segx_pkg::segx_kind_type  acc_kind;    // Kind of access.
  logic [15:0]              acc_vaddr;   // Virtual address.
  logic                     dma_choice;  // DMA segment choice bit.
  logic                     use_int_seg; // Compatibility service routine active.
  logic [5:0]               code_seg;    // Code segment.
  logic [5:0]               int_seg;     // Interrupt segment.
  logic [5:0]               dma_seg;     // DMA segment.
  logic [3:0][7:0]          page;        // Data page selects.
  logic [21:0]              phys_addr;   // Registered physical address.
  logic                     phys_valid;  // Registered address valid.
  modport ctrl   (output acc_valid, acc_kind, acc_vaddr, dma_choice, use_int_seg, code_seg, int_seg, dma_seg,
                  page, input phys_addr, phys_valid);
  modport former (input acc_valid, acc_kind, acc_vaddr, dma_choice, use_int_seg, code_seg, int_seg, dma_seg,
                  page, output phys_addr, phys_valid);
endinterface : segx_map_if

// *** src/segx_addr_former.sv ***
`timescale 1ns/1ps
module segx_addr_former (
  input logic         clk_sys, // System clock.
  input logic         reset_n, // Asynchronous reset, active low.
  segx_map_if.former  m        // Segment state in, physical address out.
);
  logic [21:0] next_phys;
  logic        next_valid;

  // Select the upper address bits by access kind; the address is held when idle.
  always_comb begin
    next_valid = m.acc_valid;
    next_phys  = m.phys_addr;
    if (m.acc_valid) begin
      unique case (m.acc_kind)
        segx_pkg::kind_code: next_phys = {(m.use_int_seg ? m.int_seg : m.code_seg), m.acc_vaddr}; // [RULE1] [RULE3] [RULE6] [RULE16]
        segx_pkg::kind_data: next_phys = {m.page[m.acc_vaddr[15:14]], m.acc_vaddr[13:0]}; // [RULE15] [RULE12]
        segx_pkg::kind_dma:  next_phys = {(m.dma_choice ? m.dma_seg : m.int_seg), m.acc_vaddr}; // [RULE4] [RULE5]
        default:             next_phys = m.phys_addr;
      endcase
    end
  end

  // Register the result so the top outputs come from flip-flops.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      m.phys_addr  <= 22'h000000;
      m.phys_valid <= 1'b0;
    end else begin
      m.phys_addr  <= next_phys;
      m.phys_valid <= next_valid;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_data_page;
    m.acc_valid && m.acc_kind == segx_pkg::kind_data |=> m.phys_addr[21:14] == $past(m.page[m.acc_vaddr[15:14]]);
  endproperty
  a_data_page: assert property (p_data_page) else $error("Data page not applied."); // [RULE15]

  property p_dma_seg;
    m.acc_valid && m.acc_kind == segx_pkg::kind_dma |=>
      m.phys_addr[21:16] == ($past(m.dma_choice) ? $past(m.dma_seg) : $past(m.int_seg));
  endproperty
  a_dma_seg: assert property (p_dma_seg) else $error("DMA segment wrong."); // [RULE4] [RULE5]
endmodule : segx_addr_former

// *** sim/segx_prog_mem.sv ***
`timescale 1ns/1ps
// Program memory behind the vector fetcher; it serves each byte request once, promptly or late.
module segx_prog_mem (
  input  wire logic        clk_sys,       // System clock.
  input  wire logic        reset_n,       // Asynchronous reset, active low.
  input  wire logic        vec_mem_valid, // Byte request.
  input  wire logic [21:0] vec_mem_addr,  // Byte address.
  input  wire logic        slow,          // Insert three wait cycles.
  output logic      [7:0]  mem_rdata,     // Returned byte.
  output logic             mem_rvalid     // Returned byte valid.
);
  logic [1:0] wait_cnt;
  // The cycle of rest after each answer lets the fetcher step its address before another byte is served.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 2'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 8'h00;
    end else if (vec_mem_valid && !mem_rvalid && (!slow || wait_cnt == 2'h3)) begin
      wait_cnt <= 2'h0;
      mem_rvalid <= 1'b1;
      mem_rdata <= vec_mem_addr[7:0] + {2'h0, vec_mem_addr[21:16]}; // Byte depends on every segment bit.
    end else begin
      wait_cnt <= (vec_mem_valid && !mem_rvalid) ? wait_cnt + 2'h1 : 2'h0;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata; // An idle bus inverts the last byte each cycle, so it shows it again every second cycle.
    end
  end
endmodule : segx_prog_mem

// *** sim/segx_top_tb.sv ***
`timescale 1ns/1ps
`include "segx_cfg.svh"
module segx_top_tb;
  localparam logic [5:0] mp = `SEGX_PAGE_MMU;
  logic                    clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_hit, port_remap;
  logic [5:0]              reg_page = 6'h00, iret_seg = 6'h00, seg_load_val = 6'h00, push_seg, cseg, iseg, dseg;
  logic [7:0]              reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, mem_rdata;
  logic                    acc_valid = 1'b0, dma_seg_choice = 1'b0, phys_valid, int_enter = 1'b0, iret = 1'b0;
  logic                    seg_load = 1'b0, push_seg_valid, in_service, vec_req = 1'b0, vec_mem_valid, mem_rvalid;
  logic                    vec_done, vec_busy, mem_slow = 1'b0, rd_seen = 1'b0;
  segx_pkg::segx_kind_type acc_kind = segx_pkg::kind_code;
  segx_pkg::segx_vec_type  vec_sel = segx_pkg::vec_reset;
  logic [15:0]             acc_vaddr = 16'h0000, vec_target, va;
  logic [21:0]             phys_addr, vec_mem_addr;
  logic [3:0][7:0]         pg;
  logic [31:0]             seed = 32'h00000052, r;
  logic [23:0]             q[4][$];
  logic [7:0]              map_a[8] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf6, 8'hf8, 8'hf9};
  int                      errors = 0, compares = 0, cycles = 0;

  segx_top u_dut (.*);
  segx_prog_mem u_mem (.clk_sys(clk_sys), .reset_n(reset_n), .vec_mem_valid(vec_mem_valid),
    .vec_mem_addr(vec_mem_addr), .slow(mem_slow), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  // Free-running 200 MHz clock.
  always #2.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] mb(input logic [21:0] a);
    return a[7:0] + {2'h0, a[21:16]};
  endfunction : mb
  // An empty queue yields an unknown note, so an unasked-for result always counts as a mismatch.
  function automatic logic [23:0] pop(input int k);
    return (q[k].size() > 0) ? q[k].pop_front() : 24'hxxxxxx;
  endfunction : pop
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  // Every request starts on its own falling edge and lasts exactly one sampling edge.
  task automatic reg_op(input logic wr, input logic [5:0] p, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_page = p;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = wr;
    reg_rd = !wr;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : reg_op
  task automatic rd(input logic [5:0] p, input logic [7:0] a, input logic [8:0] e);
    q[0].push_back({15'h0000, e});
    reg_op(1'b0, p, a, 8'h00);
  endtask : rd
  task automatic acc(input segx_pkg::segx_kind_type k, input logic [15:0] v, input logic [21:0] e);
    q[1].push_back({2'b00, e});
    @(negedge clk_sys);
    acc_kind = k;
    acc_vaddr = v;
    acc_valid = 1'b1;
    @(negedge clk_sys);
    acc_valid = 1'b0;
  endtask : acc
  task automatic ev(input logic [2:0] e);
    @(negedge clk_sys);
    {int_enter, iret, seg_load} = e;
    @(negedge clk_sys);
    {int_enter, iret, seg_load} = 3'b000;
  endtask : ev
  // Waits on busy with a bound, since the memory may answer late.
  task automatic vec(input segx_pkg::segx_vec_type s, input logic [21:0] a);
    q[2].push_back({8'h00, mb(a), mb(a + 22'h000001)});
    @(negedge clk_sys);
    vec_sel = s;
    vec_req = 1'b1;
    @(negedge clk_sys);
    vec_req = 1'b0;
    for (int i = 0; i < 40 && vec_busy === 1'b1; i++) @(negedge clk_sys);
    check("vec_busy", {23'h000000, vec_busy}, 24'h000000);
  endtask : vec

  // Read answers belong to the read sampled one edge earlier.
  always @(posedge clk_sys) rd_seen <= reg_rd;
  // Results are matched in order against the notes left by the driver.
  always @(negedge clk_sys) begin
    if (reset_n && rd_seen) check("reg_rdata", {15'h0000, reg_hit, reg_rdata}, pop(0));
    if (reset_n && phys_valid) check("phys_addr", {2'b00, phys_addr}, pop(1));
    if (reset_n && vec_done) check("vec_target", {8'h00, vec_target}, pop(2));
    if (reset_n && push_seg_valid) check("push_seg", {18'h00000, push_seg}, pop(3));
  end
  // The whole run needs under a thousand cycles, so this ceiling only trips on a hang.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    foreach (map_a[i]) rd(mp, map_a[i], 9'h100);
    r = rnd();
    cseg = r[5:0];
    iseg = r[11:6];
    dseg = r[17:12];
    pg = rnd();
    // The code segment is set by a segment jump, never by a direct write in normal execution.
    seg_load_val = cseg;
    ev(3'b001);
    reg_op(1'b1, mp, `SEGX_OFF_ISEG, {2'b10, iseg});
    reg_op(1'b1, mp, `SEGX_OFF_DSEG, {2'b01, dseg});
    for (int i = 0; i < 4; i++) reg_op(1'b1, mp, `SEGX_OFF_PAGE0 + i[7:0], pg[i]);
    rd(mp, `SEGX_OFF_CSEG, {3'b100, cseg});
    rd(mp, `SEGX_OFF_ISEG, {3'b100, iseg});
    rd(mp, `SEGX_OFF_DSEG, {3'b100, dseg});
    rd(mp, 8'hf5, 9'h000);
    rd(6'h00, `SEGX_OFF_CSEG, 9'h000);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      va = {i[1:0], r[13:0]};
      acc(segx_pkg::kind_data, va, {pg[i], va[13:0]});
      acc(segx_pkg::kind_code, r[31:16], {cseg, r[31:16]});
      dma_seg_choice = 1'b0;
      acc(segx_pkg::kind_dma, r[31:16], {iseg, r[31:16]});
      dma_seg_choice = 1'b1;
      acc(segx_pkg::kind_dma, r[31:16], {dseg, r[31:16]});
    end
    // Relocation moves the page selects to the group below and frees their normal slots.
    reg_op(1'b1, mp, `SEGX_OFF_MODE, 8'h20);
    rd(mp, `SEGX_OFF_MODE, 9'h120);
    check("port_remap", {23'h000000, port_remap}, 24'h000001);
    rd(mp, `SEGX_OFF_PAGE0, 9'h000);
    pg[3] = r[23:16];
    reg_op(1'b1, 6'h00, `SEGX_OFF_PAGE0_ALT + 8'h03, pg[3]);
    rd(6'h00, `SEGX_OFF_PAGE0_ALT + 8'h03, {1'b1, pg[3]});
    acc(segx_pkg::kind_data, 16'hc123, {pg[3], 14'h0123});
    reg_op(1'b1, mp, `SEGX_OFF_MODE, 8'h00);
    // Compatibility entry: fetches follow the interrupt segment until the return.
    ev(3'b100);
    check("in_service", {23'h000000, in_service}, 24'h000001);
    acc(segx_pkg::kind_code, r[15:0], {iseg, r[15:0]});
    seg_load_val = r[21:16];
    ev(3'b001);
    cseg = r[21:16];
    acc(segx_pkg::kind_code, r[15:0], {iseg, r[15:0]});
    acc(segx_pkg::kind_data, 16'h0456, {pg[0], 14'h0456});
    vec(segx_pkg::vec_top, {iseg, `SEGX_VEC_TOP});
    vec(segx_pkg::vec_divzero, {iseg, `SEGX_VEC_DIVZERO});
    cseg = r[27:22];
    reg_op(1'b1, mp, `SEGX_OFF_CSEG, {2'b00, cseg});
    ev(3'b010);
    check("in_service", {23'h000000, in_service}, 24'h000000);
    acc(segx_pkg::kind_code, r[15:0], {cseg, r[15:0]});
    mem_slow = 1'b1;
    vec(segx_pkg::vec_reset, {cseg, `SEGX_VEC_RESET});
    // Save mode: the old code segment is pushed, then restored by the return.
    reg_op(1'b1, mp, `SEGX_OFF_MODE, 8'h40);
    q[3].push_back({18'h00000, cseg});
    ev(3'b100);
    check("in_service", {23'h000000, in_service}, 24'h000000);
    acc(segx_pkg::kind_code, r[15:0], {iseg, r[15:0]});
    acc(segx_pkg::kind_data, 16'h4789, {pg[1], 14'h0789});
    iret_seg = cseg;
    ev(3'b010);
    acc(segx_pkg::kind_code, r[15:0], {cseg, r[15:0]});
    repeat (3) @(negedge clk_sys);
    check("notes", 24'(q[0].size() + q[1].size() + q[2].size() + q[3].size()), 24'h000000);
    test_done();
  end
endmodule : segx_top_tb
